// [rtl/rtc_timer_pkg.sv]
// Constants, field positions and types for the periodic countdown timer.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register port.
package rtc_timer_pkg;

    // **********************************************************
    // Clock and time base
    // **********************************************************
    localparam int CLK_HZ = 10_000_000; // System clock rate
    localparam int CLK_PERIOD_NS = 100; // System clock period
    localparam int SRC_BASE_HZ = 4096; // Fastest source tap
    // Cycles per 4096 Hz tick, rounded down
    localparam int CYC_PER_BASE = CLK_HZ / SRC_BASE_HZ;
    // Divider chain: 4096->64->1 Hz->1/60->1/3600
    localparam int DIV_STAGES = 4;
    localparam int DIV_64HZ = 64;
    localparam int DIV_1HZ = 64;
    localparam int DIV_MIN = 60;
    localparam int DIV_HOUR = 60;

    // **********************************************************
    // Interrupt auto-release times
    // **********************************************************
    localparam int REL_FAST_NS = 122_000; // With the 4096 Hz tap
    localparam int REL_SLOW_NS = 7_813_000; // With any slower tap
    localparam int REL_FAST_CYC = REL_FAST_NS / CLK_PERIOD_NS;
    localparam int REL_SLOW_CYC = REL_SLOW_NS / CLK_PERIOD_NS;

    // **********************************************************
    // Register map (byte addresses)
    // **********************************************************
    localparam logic [4:0] ADDR_PRESET = 5'h00; // Preset / count
    localparam logic [4:0] ADDR_CTRL = 5'h04; // Control bits
    localparam logic [4:0] ADDR_FLAG = 5'h08; // Event flag, state
    localparam logic [4:0] ADDR_ISTS = 5'h0C; // Sticky status
    localparam logic [4:0] ADDR_IMASK = 5'h10; // Interrupt mask

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_IE_BIT = 1;
    localparam int CTRL_PAUSE_BIT = 2;
    localparam int CTRL_ROUTE_BIT = 3;
    localparam int CTRL_STOP_BIT = 4;
    localparam int CTRL_SEL_LSB = 8;
    // Flag register fields
    localparam int FLAG_EVENT_BIT = 0;
    localparam int FLAG_IRQ_BIT = 1;
    localparam int FLAG_PIN_A_BIT = 2;
    localparam int FLAG_PIN_B_BIT = 3;
    // Sticky status and mask fields
    localparam int ISTS_EVENT_BIT = 0;
    localparam int ISTS_START_BIT = 1;

    // **********************************************************
    // Reset values
    // **********************************************************
    localparam logic [15:0] PRESET_RST = 16'h0000;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic WAITREQ_RST = 1'b1;

    // Source tap codes
    localparam logic [2:0] SEL_4096HZ = 3'h0;
    localparam logic [2:0] SEL_64HZ = 3'h1;
    localparam logic [2:0] SEL_1HZ = 3'h2;
    localparam logic [2:0] SEL_MIN = 3'h3;
    localparam logic [2:0] SEL_HOUR = 3'h4;

    // Countdown run state
    typedef enum logic [1:0] {T_IDLE, T_ARMED, T_RUN} timer_state_t;

endpackage

// [rtl/tick_source.sv]
// Source clock taps for the countdown: a divider chain from the
// system clock down to one tick per hour, one tap selected.
// Assumes clk and srst of the timer's own domain.
`timescale 1ns/1ns
module tick_source
import rtc_timer_pkg::*;
#(
    parameter int CYC_BASE = CYC_PER_BASE
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] tick_select,
    output logic tick
);

    // **********************************************************
    // State
    // **********************************************************
    typedef struct packed {
        logic [15:0] base_cnt; // Cycles within a 4096 Hz period
        logic [DIV_STAGES-1:0][5:0] div_cnt; // Chain stage counts
        logic tick; // Selected tick pulse
    } tick_state_t;

    tick_state_t r_reg; // Registered state
    tick_state_t r_next; // Next state
    logic [DIV_STAGES:0] carry; // Tick of each tap, fastest first

    // Divisor of one chain stage
    function automatic logic [5:0] stage_div(input int idx);
        case (idx)
            0: stage_div = 6'(DIV_64HZ - 1);
            1: stage_div = 6'(DIV_1HZ - 1);
            2: stage_div = 6'(DIV_MIN - 1);
            default: stage_div = 6'(DIV_HOUR - 1);
        endcase
    endfunction

    // Base tick when the cycle count wraps
    assign carry[0] = (r_reg.base_cnt == 16'(CYC_BASE - 1));

    // Each stage passes a tick on when it wraps
    genvar gi;
    generate
        for (gi = 0; gi < DIV_STAGES; gi++)
        begin : g_stage
            assign carry[gi+1] = carry[gi] &&
                (r_reg.div_cnt[gi] == stage_div(gi));
        end
    endgenerate

    // **********************************************************
    // Next state
    // **********************************************************
    always_comb
    begin
        r_next = r_reg;
        // Free-running base counter
        if (carry[0])
            r_next.base_cnt = 16'h0000;
        else
            r_next.base_cnt = r_reg.base_cnt + 16'h0001;
        // Chain stages advance on the tick below them
        for (int i = 0; i < DIV_STAGES; i++)
        begin
            if (carry[i])
            begin
                if (r_reg.div_cnt[i] == stage_div(i))
                    r_next.div_cnt[i] = 6'h00;
                else
                    r_next.div_cnt[i] = r_reg.div_cnt[i] + 6'h01;
            end
        end
        // Unused codes give no tick at all
        if (tick_select <= SEL_HOUR)
            r_next.tick = carry[tick_select];
        else
            r_next.tick = 1'b0;
    end

    // Registered state
    always_ff @(posedge clk)
    begin
        if (srst)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign tick = r_reg.tick;

endmodule

// [rtl/periodic_countdown_timer_irq.sv]
// Periodic countdown timer with open-drain interrupt routing.
// Assumes an Avalon-MM master on clk, and the serial link clock
// arriving from outside the clock domain.
//
// Functional notes
// - Enable low: counter reads return the preset
// - Enable cleared halts; asserted interrupt stays low
// - Enable rising always restarts from the preset
// - Each event sets flag, held until cleared
// - Flag clear leaves asserted interrupt output alone
// - Writing one to flag changes nothing
// - Interrupt enabled: event drives selected output low
// - Interrupt disabled: no output; clearing releases it
// - Pause freezes count; resume from frozen count
// - Clock stop halts all but 4096 Hz tap
// - Route bit: zero pin b, one pin a
// - Countdown starts at link clock rising edge
// - Interval is preset times tick; zero undefined
// - Event on 0001h to 0000h, then reload
// - Three-bit select picks source tick rate
// - Output auto-releases after 122 us or 7.813 ms
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
module periodic_countdown_timer_irq
import rtc_timer_pkg::*;
#(
    parameter int CYC_BASE = CYC_PER_BASE,
    parameter int REL_SLOW = REL_SLOW_CYC
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic link_scl,
    input wire logic irq_out_a_n_in,
    output logic irq_out_a_n,
    output logic irq_out_a_n_oe,
    input wire logic irq_out_b_n_in,
    output logic irq_out_b_n,
    output logic irq_out_b_n_oe,
    output logic irq
);

    // **********************************************************
    // State
    // **********************************************************
    typedef struct packed {
        logic waitreq; // Bus answer strobe, low for one cycle
        logic [31:0] rdata; // Read data latched for the answer
        logic [15:0] preset; // Reload value
        logic [15:0] count; // Running count
        logic en; // timer_enable
        logic ie; // timer_irq_enable
        logic pause; // timer_pause
        logic route; // timer_irq_route
        logic stop; // Clock stop from the rest of the clock
        logic [2:0] sel; // tick_select_hi/mid/lo
        logic flag; // timer_event_flag
        logic irq_on; // Interrupt output asserted
        logic [23:0] rel_cnt; // Cycles left before auto release
        timer_state_t tstate; // Countdown run state
        logic scl_s1; // Link clock synchroniser, first stage
        logic scl_s2; // Link clock synchroniser, second stage
        logic scl_s3; // Previous synchronised level
        logic pa_s1; // Pin a level, first stage
        logic pa_s2; // Pin a level, second stage
        logic pb_s1; // Pin b level, first stage
        logic pb_s2; // Pin b level, second stage
        logic [1:0] ists; // Sticky interrupt status
        logic [1:0] imask; // Interrupt mask
        logic irq; // Level interrupt to software
        logic oe_a; // Drive pin a low
        logic oe_b; // Drive pin b low
        logic od_level; // Level driven while enabled
    } timer_regs_t;

    timer_regs_t r_reg; // Registered state
    timer_regs_t r_next; // Next state
    logic tick; // Selected source tick
    logic scl_rise; // Synchronised link clock rising edge
    logic ev; // Countdown event this cycle
    logic started; // Countdown started this cycle
    logic take_wr; // Write taken this cycle
    logic stop_halt; // Clock stop freezes this tap

    // Address match, used by reads and writes alike
    function automatic logic hit(input logic [4:0] a,
                                 input logic [4:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // **********************************************************
    // Source tick
    // **********************************************************
    tick_source #(
        .CYC_BASE(CYC_BASE)
    ) u_tick (
        .clk(clk),
        .srst(srst),
        .tick_select(r_reg.sel),
        .tick(tick)
    );

    // Edge of the link clock, seen after the synchroniser
    assign scl_rise = r_reg.scl_s2 && !r_reg.scl_s3;
    // Only the fastest tap keeps running under clock stop
    assign stop_halt = r_reg.stop && (r_reg.sel != SEL_4096HZ);

    // **********************************************************
    // Next state
    // **********************************************************
    always_comb
    begin
        r_next = r_reg;
        ev = 1'b0;
        started = 1'b0;
        // Synchronisers
        r_next.scl_s1 = link_scl;
        r_next.scl_s2 = r_reg.scl_s1;
        r_next.scl_s3 = r_reg.scl_s2;
        r_next.pa_s1 = irq_out_a_n_in;
        r_next.pa_s2 = r_reg.pa_s1;
        r_next.pb_s1 = irq_out_b_n_in;
        r_next.pb_s2 = r_reg.pb_s1;

        // Bus: answer one cycle after a request appears
        r_next.waitreq = !((read || write) && r_reg.waitreq);
        take_wr = write && !r_reg.waitreq;
        if (read && r_reg.waitreq)
        begin
            r_next.rdata = 32'h00000000;
            // Unmapped addresses read as zero
            if (hit(address, ADDR_PRESET))
                r_next.rdata[15:0] = r_reg.en ? r_reg.count
                                              : r_reg.preset;
            else if (hit(address, ADDR_CTRL))
            begin
                r_next.rdata[CTRL_EN_BIT] = r_reg.en;
                r_next.rdata[CTRL_IE_BIT] = r_reg.ie;
                r_next.rdata[CTRL_PAUSE_BIT] = r_reg.pause;
                r_next.rdata[CTRL_ROUTE_BIT] = r_reg.route;
                r_next.rdata[CTRL_STOP_BIT] = r_reg.stop;
                r_next.rdata[CTRL_SEL_LSB+:3] = r_reg.sel;
            end
            else if (hit(address, ADDR_FLAG))
            begin
                r_next.rdata[FLAG_EVENT_BIT] = r_reg.flag;
                r_next.rdata[FLAG_IRQ_BIT] = r_reg.irq_on;
                r_next.rdata[FLAG_PIN_A_BIT] = r_reg.pa_s2;
                r_next.rdata[FLAG_PIN_B_BIT] = r_reg.pb_s2;
            end
            else if (hit(address, ADDR_ISTS))
                r_next.rdata[1:0] = r_reg.ists;
            else if (hit(address, ADDR_IMASK))
                r_next.rdata[1:0] = r_reg.imask;
        end

        // Countdown; pause and clock stop freeze the count
        if (r_reg.tstate == T_RUN && tick && !r_reg.pause
            && !stop_halt)
        begin
            if (r_reg.count == 16'h0001)
            begin
                ev = 1'b1;
                r_next.count = r_reg.preset;
            end
            else if (r_reg.count != 16'h0000)
                r_next.count = r_reg.count - 16'h0001;
            // A zero preset just sits: no event is ever made
        end
        // Armed countdown starts on the link clock edge
        if (r_reg.tstate == T_ARMED && scl_rise)
        begin
            r_next.tstate = T_RUN;
            r_next.count = r_reg.preset;
            started = 1'b1;
        end

        // Auto release of the asserted interrupt output
        if (r_reg.irq_on)
        begin
            if (r_reg.rel_cnt <= 24'h000001)
                r_next.irq_on = 1'b0;
            else
                r_next.rel_cnt = r_reg.rel_cnt - 24'h000001;
        end
        if (ev && r_reg.ie)
        begin
            r_next.irq_on = 1'b1;
            if (r_reg.sel == SEL_4096HZ)
                r_next.rel_cnt = 24'(REL_FAST_CYC);
            else
                r_next.rel_cnt = 24'(REL_SLOW);
        end

        // Register writes, taken on the edge waitrequest is low
        if (take_wr && hit(address, ADDR_PRESET))
        begin
            // Software stops the timer before loading this
            if (byteenable[0])
                r_next.preset[7:0] = writedata[7:0];
            if (byteenable[1])
                r_next.preset[15:8] = writedata[15:8];
        end
        if (take_wr && hit(address, ADDR_CTRL) && byteenable[0])
        begin
            r_next.en = writedata[CTRL_EN_BIT];
            r_next.ie = writedata[CTRL_IE_BIT];
            r_next.pause = writedata[CTRL_PAUSE_BIT];
            r_next.route = writedata[CTRL_ROUTE_BIT];
            r_next.stop = writedata[CTRL_STOP_BIT];
            // Halting leaves any asserted output as it is
            if (!writedata[CTRL_EN_BIT])
                r_next.tstate = T_IDLE;
            else if (!r_reg.en)
                r_next.tstate = T_ARMED;
            // Disabling the interrupt drops the output
            if (!writedata[CTRL_IE_BIT])
                r_next.irq_on = 1'b0;
        end
        if (take_wr && hit(address, ADDR_CTRL) && byteenable[1])
            r_next.sel = writedata[CTRL_SEL_LSB+:3];
        // Only a zero clears the flag; the output is not touched
        if (take_wr && hit(address, ADDR_FLAG) && byteenable[0]
            && !writedata[FLAG_EVENT_BIT])
            r_next.flag = 1'b0;
        if (take_wr && hit(address, ADDR_ISTS) && byteenable[0])
            r_next.ists = r_reg.ists & ~writedata[1:0];
        if (take_wr && hit(address, ADDR_IMASK) && byteenable[0])
            r_next.imask = writedata[1:0];

        // Set wins over a clear in the same cycle
        if (ev)
        begin
            r_next.flag = 1'b1;
            r_next.ists[ISTS_EVENT_BIT] = 1'b1;
        end
        if (started)
            r_next.ists[ISTS_START_BIT] = 1'b1;

        // Outputs, all registered
        r_next.irq = |(r_next.ists & r_next.imask);
        r_next.oe_a = r_next.irq_on && r_next.route;
        r_next.oe_b = r_next.irq_on && !r_next.route;
        r_next.od_level = 1'b0;
    end

    // Registered state
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_reg <= '0;
            r_reg.waitreq <= WAITREQ_RST;
            r_reg.preset <= PRESET_RST;
            r_reg.sel <= SEL_RST;
        end
        else
            r_reg <= r_next;
    end

    assign readdata = r_reg.rdata;
    assign waitrequest = r_reg.waitreq;
    assign irq_out_a_n = r_reg.od_level;
    assign irq_out_a_n_oe = r_reg.oe_a;
    assign irq_out_b_n = r_reg.od_level;
    assign irq_out_b_n_oe = r_reg.oe_b;
    assign irq = r_reg.irq;

    // **********************************************************
    // Assertions
    // **********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // A write to the control register being taken
    sequence s_ctrl_wr;
        take_wr && hit(address, ADDR_CTRL) && byteenable[0];
    endsequence
    // An event with the interrupt enabled and no control write
    sequence s_irq_event;
        ev && r_reg.ie && !(take_wr && hit(address, ADDR_CTRL));
    endsequence

    AST_READ_PRESET_IDLE: assert property (
        read && r_reg.waitreq && hit(address, ADDR_PRESET) && !r_reg.en
        |=> readdata[15:0] == $past(r_reg.preset))
        else $error("idle read did not return preset");
    AST_DISABLE_KEEPS_IRQ: assert property (
        s_ctrl_wr and (!writedata[CTRL_EN_BIT] && writedata[CTRL_IE_BIT]
        && r_reg.irq_on && r_reg.rel_cnt > 24'h000001)
        |=> r_reg.irq_on && r_reg.tstate == T_IDLE)
        else $error("enable clear changed interrupt output");
    AST_START_FROM_PRESET: assert property (
        r_reg.tstate == T_ARMED && scl_rise && !take_wr
        |=> r_reg.tstate == T_RUN && r_reg.count == $past(r_reg.preset))
        else $error("countdown did not start from preset");
    AST_EVENT_SETS_FLAG: assert property (
        ev && !take_wr
        |=> r_reg.flag && r_reg.count == $past(r_reg.preset))
        else $error("event did not set flag and reload");
    AST_FLAG_CLEAR_KEEPS_IRQ: assert property (
        take_wr && hit(address, ADDR_FLAG) && byteenable[0]
        && !writedata[FLAG_EVENT_BIT] && r_reg.irq_on
        && r_reg.rel_cnt > 24'h000001 && !ev
        |=> r_reg.irq_on && !r_reg.flag
        && (irq_out_a_n_oe || irq_out_b_n_oe))
        else $error("flag clear released the interrupt output");
    AST_FLAG_ONE_IGNORED: assert property (
        take_wr && hit(address, ADDR_FLAG) && writedata[FLAG_EVENT_BIT]
        && !ev
        |=> $stable(r_reg.flag))
        else $error("writing one changed the flag");
    AST_EVENT_DRIVES_PIN: assert property (
        s_irq_event
        |=> irq_out_a_n_oe == r_reg.route
        && irq_out_b_n_oe == !r_reg.route && !irq_out_a_n)
        else $error("event did not drive the routed pin");
    AST_NO_IRQ_DISABLED: assert property (
        !r_reg.ie |=> !r_reg.irq_on && !irq_out_a_n_oe && !irq_out_b_n_oe)
        else $error("interrupt output with interrupt disabled");
    AST_PAUSE_FREEZES: assert property (
        r_reg.tstate == T_RUN && r_reg.pause && !take_wr
        |=> $stable(r_reg.count))
        else $error("count moved while paused");
    AST_STOP_FREEZES: assert property (
        r_reg.tstate == T_RUN && stop_halt && !take_wr
        |=> $stable(r_reg.count))
        else $error("count moved under clock stop");
    AST_RELEASE_TIME: assert property (
        s_irq_event ##0 (r_reg.sel == SEL_4096HZ)
        |=> r_reg.irq_on && r_reg.rel_cnt == 24'(REL_FAST_CYC))
        else $error("fast auto release time not loaded");

endmodule

// [bench/link_host_model.sv]
// Far side: serial host clock and the pulled-up interrupt wires.
// Assumes the bench calls write_frame after each write that raises enable.
`timescale 1ns/1ns
module link_host_model
(
    input wire logic oe_a,
    input wire logic oe_b,
    input wire logic out_a,
    input wire logic out_b,
    output logic scl,
    output logic wire_a,
    output logic wire_b
);
    // **********************************************************
    // Open-drain wires, pulled high when nobody drives
    // **********************************************************
    assign wire_a = oe_a ? out_a : 1'b1;
    assign wire_b = oe_b ? out_b : 1'b1;

    // Serial clock stands high between frames
    initial scl = 1'b1;

    // The enable write travels on the register bus; the serial side
    // gives only the acknowledge clock that completes it
    task automatic write_frame();
        #400 scl = 1'b0;
        #400 scl = 1'b1;
    endtask
endmodule

// [bench/periodic_countdown_timer_irq_bench.sv]
// Self-checking bench for the countdown timer.
// Assumes a base tick of CB cycles and the far-side model.
`timescale 1ns/1ns
module periodic_countdown_timer_irq_bench;
import rtc_timer_pkg::*;
    localparam int CB = 4; // Short base tick keeps runs brief
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic scl, wa, wb, oa, ob, ea, eb, irq;
    logic [31:0] v, w;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    int p, c0, n, seed;
    int q[$]; // Cycle stamps of interrupt rises

    // **********************************************************
    // Clock, cycle counter, design and far side
    // **********************************************************
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    periodic_countdown_timer_irq #(.CYC_BASE(CB), .REL_SLOW(50)) dut (
        .clk(clk), .srst(srst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .link_scl(scl), .irq_out_a_n_in(wa), .irq_out_a_n(oa),
        .irq_out_a_n_oe(ea), .irq_out_b_n_in(wb), .irq_out_b_n(ob),
        .irq_out_b_n_oe(eb), .irq(irq));

    link_host_model far (.oe_a(ea), .oe_b(eb), .out_a(oa), .out_b(ob),
        .scl(scl), .wire_a(wa), .wire_b(wb));

    // **********************************************************
    // Reporting and bus tasks
    // **********************************************************
    task automatic final_report();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compare one value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // One Avalon access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50)
        begin
            fails++;
            final_report();
        end
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    // Bounded wait for a one on the given wire
    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= lim)
        begin
            fails++;
            final_report();
        end
    endtask

    // **********************************************************
    // Main sequence
    // **********************************************************
    initial
    begin
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        seed = $urandom(32'h23D8);
        p = 8 + ($urandom % 8); // Preset 8..15
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        bus(1'b1, 5'h14, 32'hFFFF, v); // Unmapped write ignored
        bus(1'b0, 5'h14, 0, v);
        check(v, 32'h0);
        bus(1'b0, ADDR_CTRL, 0, v);
        check(v, 32'h0);
        bus(1'b1, ADDR_PRESET, p, v);
        bus(1'b0, ADDR_PRESET, 0, v);
        check(v, p);
        bus(1'b1, ADDR_IMASK, 32'h1, v);
        bus(1'b1, ADDR_CTRL, 32'hB, v); // Enable, irq on, pin a
        far.write_frame();
        // Interval between events is preset times the tick
        repeat (3)
        begin
            wait_hi(irq, 200);
            q.push_back(cyc);
            bus(1'b1, ADDR_ISTS, 32'h1, v);
            repeat (3) @(posedge clk);
        end
        check(q[1] - q[0], p * CB);
        check(q[2] - q[1], p * CB);
        check({ea, eb, wa}, 3'b100);
        wait_hi(irq, 200);
        bus(1'b1, ADDR_FLAG, 32'h1, v);
        bus(1'b0, ADDR_FLAG, 0, v);
        check(v[0], 1'b1);
        bus(1'b1, ADDR_FLAG, 32'h0, v);
        bus(1'b0, ADDR_FLAG, 0, v);
        check({v[0], ea}, 2'b01);
        bus(1'b1, ADDR_CTRL, 32'hF, v); // Pause
        bus(1'b0, ADDR_PRESET, 0, v);
        repeat (40) @(posedge clk);
        bus(1'b0, ADDR_PRESET, 0, w);
        check(w, v);
        bus(1'b1, ADDR_CTRL, 32'h9, v); // Irq enable off
        repeat (2 * p * CB) @(posedge clk);
        check({ea, eb}, 2'b00);
        bus(1'b1, ADDR_CTRL, 32'hB, v);
        wait_hi(ea, 200);
        c0 = cyc;
        bus(1'b1, ADDR_CTRL, 32'hA, v); // Disable, irq stays on
        @(posedge clk); // Let the write take effect before looking
        check(ea, 1'b1);
        bus(1'b1, ADDR_ISTS, 32'h1, v);
        wait_hi(wa, 1400);
        check(cyc - c0 >= 1216 && cyc - c0 <= 1226, 1);
        check(irq, 1'b0);
        p = p + 1;
        bus(1'b1, ADDR_PRESET, p, v);
        bus(1'b1, ADDR_CTRL, 32'hB, v);
        far.write_frame();
        c0 = cyc;
        wait_hi(irq, 200);
        check(cyc - c0 <= p * CB + 6, 1);
        bus(1'b1, ADDR_CTRL, 32'h3, v); // Route to pin b
        wait_hi(eb, 200);
        check({ea, eb, wb}, 3'b010);
        bus(1'b1, ADDR_CTRL, 32'h0, v);
        bus(1'b1, ADDR_CTRL, 32'h111, v); // Stop bit, 64 Hz tap
        far.write_frame();
        repeat (300) @(posedge clk);
        bus(1'b0, ADDR_PRESET, 0, v);
        repeat (300) @(posedge clk);
        bus(1'b0, ADDR_PRESET, 0, w);
        check(w, v);
        final_report();
    end
endmodule
